// *** sensor_bank_map.vh ***
// How it works
// - The two-bit variant field selects serial mono 0x0, serial color 0x1, parallel mono 0x2 or parallel color 0x3 and resets to 0x0.
// - The PLL is held in soft reset while bits 3..0 of the PLL reset register equal 0x9.
// - The lock detector is held in soft reset while bits 7..4 of that register equal 0x9, and the register resets to 0x099.
// - Clock generator, column mux, analog front end and serializer are each held in reset while their own field equals 0x9, their reset code.
// - PLL power bit 0 low powers the PLL down, high makes it operational, and it resets low.
// - The PLL is enabled only while power bit 1 is high, and it resets low.
// - Power bit 2 high bypasses the PLL, low uses its output, and it resets high for a register value of 0x0004.
// - The clock input receiver stays powered down while I/O bit 0 is low, its reset value.
// - The clock generator takes the serial-lane clock when its select bit is 0 and the PLL clock when it is 1.
`ifndef SENSOR_BANK_MAP_VH
`define SENSOR_BANK_MAP_VH

`define ADDR_W            9
`define DATA_W            16
`define FRAME_BITS        5'd25
`define FRAME_DONE        5'd26
`define RW_BIT_POS        5'd9

`define A_IDENTITY        9'h000
`define A_RSVD_1          9'h001
`define A_VARIANT         9'h002
`define A_PLL_RESET       9'h008
`define A_CGEN_RESET      9'h009
`define A_ANALOG_RESET    9'h00A
`define A_PLL_POWER       9'h010
`define A_RSVD_17         9'h011
`define A_IO_CONFIG       9'h014
`define A_LOCK_STATUS     9'h018
`define A_RSVD_26         9'h01A
`define A_RSVD_27         9'h01B
`define A_CGEN_CONFIG     9'h020

`define RST_VARIANT       2'h0
`define RST_PLL_RESET     8'h99
`define RST_CGEN_RESET    4'h9
`define RST_ANALOG_RESET  12'h999
`define RST_PLL_POWER     3'h4
`define RST_RSVD_17       16'h2113
`define RST_IO_CONFIG     1'h0
`define RST_RSVD_26       15'h2182
`define RST_RSVD_27       16'h3D2D
`define RST_CGEN_CONFIG   4'h4

`define SOFT_RESET_CODE   4'h9
`define PWR_ON_BIT        0
`define PWR_EN_BIT        1
`define PWR_BYPASS_BIT    2
`define CGEN_SEL_PLL_BIT  2

`endif

// *** sensor_bank_props.sv ***
`timescale 1ns/1ns
`default_nettype none
module sensor_bank_props (
  input wire logic       clk_sys_in,
  input wire logic       reset_n_in,
  input wire logic       ce_in,
  input wire logic       spi_cs_n_in,
  input wire logic [1:0] variant_out,
  input wire logic       pll_hold_reset_out,
  input wire logic       lock_det_hold_reset_out,
  input wire logic       cgen_hold_reset_out,
  input wire logic       mux_hold_reset_out,
  input wire logic       afe_hold_reset_out,
  input wire logic       ser_hold_reset_out,
  input wire logic       pll_power_up_out,
  input wire logic       pll_enable_out,
  input wire logic       pll_bypass_out,
  input wire logic       clock_in_power_up_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  // First edge after release still shows the reset values
  sequence rls; $rose(reset_n_in); endsequence
  a_pll_rst_hold: assert property (rls |-> pll_hold_reset_out)
    else $error("pll not held");
  a_lock_rst_hold: assert property (rls |-> lock_det_hold_reset_out)
    else $error("detector not held");
  a_sub_rst_hold: assert property (rls |-> cgen_hold_reset_out && mux_hold_reset_out
    && afe_hold_reset_out && ser_hold_reset_out) else $error("subblock not held");
  a_pwr_rst_off: assert property (rls |-> !pll_power_up_out)
    else $error("pll powered");
  a_en_rst_off: assert property (rls |-> !pll_enable_out)
    else $error("pll enabled");
  a_byp_rst_on: assert property (rls |-> pll_bypass_out)
    else $error("pll not bypassed");
  a_clkin_rst_off: assert property (rls |-> !clock_in_power_up_out)
    else $error("clock input powered");
  a_var_rst_zero: assert property (rls |-> variant_out == 2'h0)
    else $error("variant not zero");
  // A frozen bank must not commit a frame seen meanwhile
  a_ce_freeze_hold: assert property (!$past(ce_in) |-> $stable(variant_out)
    && $stable(afe_hold_reset_out) && $stable(pll_power_up_out)) else $error("frozen change");
  // Nothing commits once the port has been idle for two cycles
  a_idle_cfg_stable: assert property (spi_cs_n_in && $past(spi_cs_n_in)
    && $past(spi_cs_n_in, 2) |-> $stable(variant_out) && $stable(pll_hold_reset_out)
    && $stable(pll_bypass_out)) else $error("change outside frame");
  c_release: cover property (rls);
  c_freeze: cover property (!ce_in ##1 ce_in);
  c_pll_live: cover property (!pll_hold_reset_out && !pll_bypass_out);
endmodule
bind sensor_reset_pll_config_bank sensor_bank_props u_props (.*);
`default_nettype wire

// *** sensor_reset_pll_config_bank.v ***
`timescale 1ns/1ns
`default_nettype none
`include "sensor_bank_map.vh"

module sensor_reset_pll_config_bank #(
  parameter [15:0] IDENTITY_VALUE = 16'hA5C3  // Arbitrary value
) (
  input  wire       clk_sys_in,
  input  wire       reset_n_in,
  input  wire       ce_in,
  input  wire       spi_sclk_in,
  input  wire       spi_cs_n_in,
  input  wire       spi_mosi_in,
  output reg        spi_miso_out,
  input  wire       pll_lock_in,
  output reg  [1:0] variant_out,
  output wire       pll_hold_reset_out,
  output wire       lock_det_hold_reset_out,
  output wire       cgen_hold_reset_out,
  output wire       mux_hold_reset_out,
  output wire       afe_hold_reset_out,
  output wire       ser_hold_reset_out,
  output wire       pll_power_up_out,
  output wire       pll_enable_out,
  output wire       pll_bypass_out,
  output wire       clock_in_power_up_out,
  output wire       cgen_clk_from_pll_out
);

  reg  [7:0]  pll_reset_q;
  reg  [3:0]  cgen_reset_q;
  reg  [11:0] analog_reset_q;
  reg  [2:0]  pll_power_q;
  reg  [15:0] rsvd_17_q;
  reg         io_config_q;
  reg         lock_q;
  reg  [14:0] rsvd_26_q;
  reg  [15:0] rsvd_27_q;
  reg  [3:0]  cgen_config_q;

  reg         sclk_prev_q;
  reg  [4:0]  bit_cnt_q;
  reg  [24:0] shift_in_q;
  reg  [15:0] shift_out_q;
  reg         is_write_q;

  // Frame, MSB first: address, direction bit, data word
  // Edges only count while selected, so stray sclk between frames is dropped
  wire        sclk_rise = spi_sclk_in & ~sclk_prev_q & ~spi_cs_n_in;
  wire        sclk_fall = ~spi_sclk_in & sclk_prev_q & ~spi_cs_n_in;
  wire        rw_now    = sclk_rise && (bit_cnt_q == `RW_BIT_POS);
  wire        wr_now    = sclk_rise && (bit_cnt_q == `FRAME_BITS) && is_write_q;
  wire [8:0]  wr_addr   = shift_in_q[24:16];
  wire [15:0] wr_data   = {shift_in_q[14:0], spi_mosi_in};
  wire [8:0]  rd_addr   = shift_in_q[8:0];

  reg  [15:0] rd_data;

  // Lock only counts while the detector runs and the PLL is up
  wire        lock_qualify = ~lock_det_hold_reset_out & pll_power_q[`PWR_ON_BIT];

  assign pll_power_up_out      = pll_power_q[`PWR_ON_BIT];
  assign pll_enable_out        = pll_power_q[`PWR_EN_BIT];
  assign pll_bypass_out        = pll_power_q[`PWR_BYPASS_BIT];
  assign clock_in_power_up_out = io_config_q;
  assign cgen_clk_from_pll_out = cgen_config_q[`CGEN_SEL_PLL_BIT];

  always @* begin
    case (rd_addr)
      `A_IDENTITY:     rd_data = IDENTITY_VALUE;
      `A_RSVD_1:       rd_data = 16'h0000;
      `A_VARIANT:      rd_data = {14'h0000, variant_out};
      `A_PLL_RESET:    rd_data = {8'h00, pll_reset_q};
      `A_CGEN_RESET:   rd_data = {12'h000, cgen_reset_q};
      `A_ANALOG_RESET: rd_data = {4'h0, analog_reset_q};
      `A_PLL_POWER:    rd_data = {13'h0000, pll_power_q};
      `A_RSVD_17:      rd_data = rsvd_17_q;
      `A_IO_CONFIG:    rd_data = {15'h0000, io_config_q};
      `A_LOCK_STATUS:  rd_data = {15'h0000, lock_q};
      `A_RSVD_26:      rd_data = {1'b0, rsvd_26_q};
      `A_RSVD_27:      rd_data = rsvd_27_q;
      `A_CGEN_CONFIG:  rd_data = {12'h000, cgen_config_q};
      default:         rd_data = 16'h0000;
    endcase
  end

  // Serial port: sclk is sampled by clk_sys_in, so sclk must run well below 10 MHz
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sclk_prev_q <= 1'b0;
      bit_cnt_q   <= 5'h00;
      shift_in_q  <= 25'h0000000;
    end else if (ce_in) begin
      sclk_prev_q <= spi_sclk_in;
      if (spi_cs_n_in) begin
        bit_cnt_q <= 5'h00;
      end else if (sclk_rise) begin
        shift_in_q <= {shift_in_q[23:0], spi_mosi_in};
        // Saturate past the last bit so trailing clocks cannot commit again
        if (bit_cnt_q != `FRAME_DONE) begin
          bit_cnt_q <= bit_cnt_q + 5'h01;
        end
      end
    end
  end

  // Read word loaded at the direction bit, shifted out on falls
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      shift_out_q  <= 16'h0000;
      is_write_q   <= 1'b0;
      spi_miso_out <= 1'b0;
    end else if (ce_in) begin
      if (spi_cs_n_in) begin
        is_write_q   <= 1'b0;
        spi_miso_out <= 1'b0;
      end else if (rw_now) begin
        is_write_q  <= spi_mosi_in;
        shift_out_q <= rd_data;
      end else if (sclk_fall && !is_write_q && bit_cnt_q > `RW_BIT_POS) begin
        spi_miso_out <= shift_out_q[15];
        shift_out_q  <= {shift_out_q[14:0], 1'b0};
      end
    end
  end

  // Register file; identity, word 1 and lock status have no write path
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      variant_out    <= `RST_VARIANT;
      pll_reset_q    <= `RST_PLL_RESET;
      cgen_reset_q   <= `RST_CGEN_RESET;
      analog_reset_q <= `RST_ANALOG_RESET;
      pll_power_q    <= `RST_PLL_POWER;
      rsvd_17_q      <= `RST_RSVD_17;
      io_config_q    <= `RST_IO_CONFIG;
      rsvd_26_q      <= `RST_RSVD_26;
      rsvd_27_q      <= `RST_RSVD_27;
      cgen_config_q  <= `RST_CGEN_CONFIG;
    end else if (ce_in) begin
      if (wr_now) begin
        case (wr_addr)
          `A_VARIANT:      variant_out    <= wr_data[1:0];
          `A_PLL_RESET:    pll_reset_q    <= wr_data[7:0];
          `A_CGEN_RESET:   cgen_reset_q   <= wr_data[3:0];
          `A_ANALOG_RESET: analog_reset_q <= wr_data[11:0];
          `A_PLL_POWER:    pll_power_q    <= wr_data[2:0];
          `A_RSVD_17:      rsvd_17_q      <= wr_data;
          `A_IO_CONFIG:    io_config_q    <= wr_data[0];
          `A_RSVD_26:      rsvd_26_q      <= wr_data[14:0];
          `A_RSVD_27:      rsvd_27_q      <= wr_data;
          `A_CGEN_CONFIG:  cgen_config_q  <= wr_data[3:0];
          // Read-only words take no write
          `A_IDENTITY:     cgen_config_q  <= cgen_config_q;
          `A_RSVD_1:       cgen_config_q  <= cgen_config_q;
          `A_LOCK_STATUS:  cgen_config_q  <= cgen_config_q;
          default:         cgen_config_q  <= cgen_config_q;
        endcase
      end
    end
  end

  // Lock flag kept apart from the write path, so no write can touch it
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lock_q <= 1'b0;
    end else if (ce_in) begin
      lock_q <= pll_lock_in & lock_qualify;
    end
  end

  // One decoder per subblock; only the exact reset code holds it

  soft_reset_decode u_pll_rst (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .ce_in      (ce_in),
    .field_in   (pll_reset_q[3:0]),
    .hold_out   (pll_hold_reset_out)
  );

  soft_reset_decode u_lock_rst (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .ce_in      (ce_in),
    .field_in   (pll_reset_q[7:4]),
    .hold_out   (lock_det_hold_reset_out)
  );

  soft_reset_decode u_cgen_rst (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .ce_in      (ce_in),
    .field_in   (cgen_reset_q),
    .hold_out   (cgen_hold_reset_out)
  );

  soft_reset_decode u_mux_rst (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .ce_in      (ce_in),
    .field_in   (analog_reset_q[3:0]),
    .hold_out   (mux_hold_reset_out)
  );

  soft_reset_decode u_afe_rst (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .ce_in      (ce_in),
    .field_in   (analog_reset_q[7:4]),
    .hold_out   (afe_hold_reset_out)
  );

  soft_reset_decode u_ser_rst (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .ce_in      (ce_in),
    .field_in   (analog_reset_q[11:8]),
    .hold_out   (ser_hold_reset_out)
  );

endmodule
`default_nettype wire

// *** sensor_reset_pll_config_bank_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module sensor_reset_pll_config_bank_bench;
  localparam [15:0] ID = 16'h5AC3;  // Arbitrary value
  reg         clk_sys_in = 1'b0;
  reg         reset_n_in = 1'b0;
  reg         ce_in = 1'b1;
  reg         sclk = 1'b0;
  reg         cs_n = 1'b1;
  reg         mosi = 1'b0;
  reg         lock = 1'b0;
  wire        miso;
  wire [12:0] outs;
  reg  [15:0] r;
  reg  [53:0] rows [0:10];
  integer     n_errors = 0;
  integer     samples_checked = 0;
  integer     i;
  sensor_reset_pll_config_bank #(.IDENTITY_VALUE(ID)) uut (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .ce_in(ce_in), .spi_sclk_in(sclk),
    .spi_cs_n_in(cs_n), .spi_mosi_in(mosi), .spi_miso_out(miso), .pll_lock_in(lock),
    .variant_out(outs[12:11]), .pll_hold_reset_out(outs[10]), .lock_det_hold_reset_out(outs[9]),
    .cgen_hold_reset_out(outs[8]), .mux_hold_reset_out(outs[7]), .afe_hold_reset_out(outs[6]),
    .ser_hold_reset_out(outs[5]), .pll_power_up_out(outs[4]), .pll_enable_out(outs[3]),
    .pll_bypass_out(outs[2]), .clock_in_power_up_out(outs[1]), .cgen_clk_from_pll_out(outs[0]));
  always #25 clk_sys_in = ~clk_sys_in;
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk_sys_in);
      #2;
    end
  endtask
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // Slow sclk gives clk_sys_in sampling margin; miso read before each of the 16 data-bit rises
  task xfer(input [8:0] a, input w, input [15:0] d, input integer n);
    reg [25:0] f;
    integer    k;
    begin
      f = {a, w, d};
      cs_n = 1'b0;
      cyc(2);
      for (k = 25; k > 25 - n; k = k - 1) begin
        mosi = f[k];
        cyc(3);
        if (k < 16) r[k] = miso;
        sclk = 1'b1;
        cyc(2);
        sclk = 1'b0;
      end
      cyc(3);
      cs_n = 1'b1;
      cyc(2);
    end
  endtask
  task rd(input [8:0] a, input [15:0] e);
    begin
      xfer(a, 1'b0, 16'h0000, 26);
      chk(r, e);
    end
  endtask
  task final_report;
    begin
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask
  initial begin
    #1000000;
    n_errors = n_errors + 1;
    final_report;
  end
  initial begin
    rows[0] = {9'h002, 16'h0003, 16'h0003, 13'h1FE5};
    rows[1] = {9'h008, 16'h0090, 16'h0090, 13'h1BE5};
    rows[2] = {9'h009, 16'h0008, 16'h0008, 13'h1AE5};
    rows[3] = {9'h00A, 16'h0A98, 16'h0A98, 13'h1A45};
    rows[4] = {9'h010, 16'h0003, 16'h0003, 13'h1A59};
    rows[5] = {9'h014, 16'h0001, 16'h0001, 13'h1A5B};
    rows[6] = {9'h020, 16'h0000, 16'h0000, 13'h1A5A};
    rows[7] = {9'h000, 16'h1111, ID, 13'h1A5A};
    rows[8] = {9'h001, 16'hFFFF, 16'h0000, 13'h1A5A};
    rows[9] = {9'h030, 16'hBEEF, 16'h0000, 13'h1A5A};
    rows[10] = {9'h011, 16'h1234, 16'h1234, 13'h1A5A};
    cyc(4);
    reset_n_in = 1'b1;
    cyc(2);
    chk(outs, 13'h07E5);
    for (i = 0; i < 11; i = i + 1) begin
      xfer(rows[i][53:45], 1'b1, rows[i][44:29], 26);
      chk(outs, rows[i][12:0]);
      rd(rows[i][53:45], rows[i][28:13]);
    end
    lock = 1'b1;
    rd(9'h018, 16'h0000);
    xfer(9'h008, 1'b1, 16'h0000, 26);
    chk(outs, 13'h185A);
    rd(9'h018, 16'h0001);
    xfer(9'h018, 1'b1, 16'h0000, 26);
    rd(9'h018, 16'h0001);
    lock = 1'b0;
    rd(9'h018, 16'h0000);
    xfer(9'h002, 1'b1, 16'h0000, 20);
    chk(outs[12:11], 2'h3);
    ce_in = 1'b0;
    xfer(9'h002, 1'b1, 16'h0000, 26);
    ce_in = 1'b1;
    cyc(2);
    chk(outs[12:11], 2'h3);
    for (i = 0; i < 4; i = i + 1) begin
      xfer(9'h002, 1'b1, i[15:0], 26);
      chk(outs[12:11], i[1:0]);
    end
    reset_n_in = 1'b0;
    cyc(4);
    reset_n_in = 1'b1;
    cyc(2);
    chk(outs, 13'h07E5);
    rd(9'h008, 16'h0099);
    rd(9'h00A, 16'h0999);
    rd(9'h010, 16'h0004);
    rd(9'h011, 16'h2113);
    rd(9'h01A, 16'h2182);
    rd(9'h01B, 16'h3D2D);
    rd(9'h020, 16'h0004);
    rd(9'h002, 16'h0000);
    rd(9'h009, 16'h0009);
    rd(9'h014, 16'h0000);
    xfer(9'h01A, 1'b1, 16'hFFFF, 26);
    rd(9'h01A, 16'h7FFF);
    final_report;
  end
endmodule
`default_nettype wire

// *** soft_reset_decode.v ***
`timescale 1ns/1ns
`default_nettype none
`include "sensor_bank_map.vh"

module soft_reset_decode (
  input  wire       clk_sys_in,
  input  wire       reset_n_in,
  input  wire       ce_in,
  input  wire [3:0] field_in,
  output reg        hold_out
);

  // Held in reset from power-on, matching the field's reset code
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hold_out <= 1'b1;
    end else if (ce_in) begin
      hold_out <= (field_in == `SOFT_RESET_CODE);
    end
  end

endmodule
`default_nettype wire
